// *** edge_sync.sv ***
// edge_sync: two-flop synchroniser with rising edge detect on the synchronised level
`timescale 1ns/1ns
module edge_sync
   import tmr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // asynchronous level in, synchronised level and edge out
   input wire logic async_in,
   output logic level,
   output logic rise
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // meta_q feeds sync_q only
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
endmodule

// *** ext_source_model.sv ***
// partner: free-running pin, crystal, sensing oscillator and gate sources
`timescale 1ns/1ns
module ext_source_model
   import tmr_pkg::*;
(
   // source lines
   output ext_in_s ext_in
);
   logic pin = 1'b0;
   logic xt = 1'b0;
   logic cap = 1'b0;
   logic gt = 1'b0;
   // even half periods never land on a rising system clock edge
   always #36 pin = !pin;
   always #46 xt = !xt;
   always #26 cap = !cap;
   always #56 gt = !gt;
   assign ext_in = {pin, xt, cap, gt};
endmodule

// *** timer_clock_source_control.sv ***
// timer_clock_source_control: counter control register, clock select, prescaler and 16-bit counter
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
// Functional notes
// - source 00 counts instruction clock (system/4); 01 counts every system clock.
// - source 11 counts capacitive sense oscillator edges.
// - source 10 counts pin rising edges, or crystal output when oscillator enabled.
// - prescale codes 00..11 divide selected clock by 1, 2, 4, 8.
// - oscillator enable bit turns the dedicated low-power oscillator on or off.
// - for source 1x, bypass bit 1 skips sync, 0 syncs; ignored for 0x.
// - run bit enables counting; clearing stops and clears gate toggle flop.
// - control bit 1 is unimplemented, ignores writes, reads zero.
// - implemented control bits reset to zero only on power-on/brown-out reset.
// - 16-bit count pair counts up to FFFF then wraps to 0000.
// - gate toggle flop flips on each rising gate edge in toggle mode.
module timer_clock_source_control
   import tmr_pkg::*;
(
   // clock and power-on/brown-out reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // external sources
   input wire ext_in_s ext_in,
   // oscillator control and status
   output logic osc_power_en,
   output logic gate_toggle,
   output logic count_tick
);
   ////////////////////////////////////////////////////////////////////////////
   ctrl_s ctrl_q, ctrl_d;
   logic tgl_en_q;
   logic [15:0] count_q, count_d;
   logic [2:0] ps_q, ps_d;
   logic [1:0] instr_q;
   logic gate_tgl_q;
   logic wr_pend_q;
   logic [11:0] addr_q;
   logic [31:0] rdata_q;
   logic osc_q;
   logic tick_q;
   logic pin_raw_q, xtal_raw_q, cap_raw_q, gate_raw_q;
   logic pin_prev_q, xtal_prev_q, cap_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // synchronised views of the asynchronous sources
   logic pin_lvl, pin_rise, xtal_lvl, xtal_rise, cap_lvl, cap_rise, gate_lvl, gate_rise;

   edge_sync u_pin (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(ext_in.ext_pin), .level(pin_lvl), .rise(pin_rise));
   edge_sync u_xtal (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(ext_in.xtal), .level(xtal_lvl), .rise(xtal_rise));
   edge_sync u_cap (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(ext_in.cap_osc), .level(cap_lvl), .rise(cap_rise));
   edge_sync u_gate (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(ext_in.gate), .level(gate_lvl), .rise(gate_rise));

   // unsynchronised path: a single sampling flop plus edge compare, one cycle less latency
   // at the price of metastability exposure, exactly what the bypass bit trades
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_raw_q <= 1'b0;
         xtal_raw_q <= 1'b0;
         cap_raw_q <= 1'b0;
         gate_raw_q <= 1'b0;
         pin_prev_q <= 1'b0;
         xtal_prev_q <= 1'b0;
         cap_prev_q <= 1'b0;
      end else begin
         pin_raw_q <= ext_in.ext_pin;
         xtal_raw_q <= ext_in.xtal;
         cap_raw_q <= ext_in.cap_osc;
         gate_raw_q <= ext_in.gate;
         pin_prev_q <= pin_raw_q;
         xtal_prev_q <= xtal_raw_q;
         cap_prev_q <= cap_raw_q;
      end
   end

   wire pin_rise_raw = pin_raw_q & ~pin_prev_q;
   wire xtal_rise_raw = xtal_raw_q & ~xtal_prev_q;
   wire cap_rise_raw = cap_raw_q & ~cap_prev_q;
   wire unused_lvls = pin_lvl ^ xtal_lvl ^ cap_lvl ^ gate_lvl ^ gate_raw_q;

   ////////////////////////////////////////////////////////////////////////////
   // source selection
   wire use_sync = ~ctrl_q.sync_bypass;
   wire pin_edge = use_sync ? pin_rise : pin_rise_raw;
   wire xtal_edge = use_sync ? xtal_rise : xtal_rise_raw;
   wire cap_edge = use_sync ? cap_rise : cap_rise_raw;
   wire ext_edge = ctrl_q.osc_en ? xtal_edge : pin_edge;
   wire instr_edge = (instr_q == INSTR_DIV_LAST);

   logic src_edge;
   always_comb begin
      unique case (ctrl_q.src)
         SRC_INSTR: src_edge = instr_edge;
         SRC_SYS: src_edge = 1'b1;
         SRC_PIN: src_edge = ext_edge;
         SRC_CAP: src_edge = cap_edge;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // prescaler: tick when the low ps bits selected by the code are all ones
   logic [2:0] ps_mask;
   always_comb begin
      unique case (ctrl_q.ps)
         2'b00: ps_mask = 3'b000;
         2'b01: ps_mask = 3'b001;
         2'b10: ps_mask = 3'b011;
         2'b11: ps_mask = 3'b111;
      endcase
   end
   wire ps_hit = ((ps_q & ps_mask) == ps_mask);
   wire inc = ctrl_q.run & src_edge & ps_hit;

   assign ps_d = !ctrl_q.run ? 3'b000 :
                 (src_edge ? (ps_hit ? 3'b000 : 3'(ps_q + 3'b001)) : ps_q);

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, always okay
   wire a_valid = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   wire [11:0] a_word = haddr & ADDR_MASK;
   wire wr_ctrl = wr_pend_q & (addr_q == CTRL_ADDR);
   wire wr_cnt = wr_pend_q & (addr_q == COUNT_ADDR);
   wire wr_gate = wr_pend_q & (addr_q == GATE_ADDR);
   wire [2:0] unused_size = hsize;

   assign ctrl_d = wr_ctrl ? ctrl_s'(hwdata[7:0] & CTRL_WMASK) : ctrl_q;
   // a software write to the count pair takes precedence over an increment
   assign count_d = wr_cnt ? hwdata[15:0] : (inc ? 16'(count_q + COUNT_ONE) : count_q);

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (a_word == CTRL_ADDR)
         rd_mux = {24'h00_0000, ctrl_q};
      else if (a_word == COUNT_ADDR)
         rd_mux = {16'h0000, count_q};
      else if (a_word == GATE_ADDR)
         rd_mux = {30'h0000_0000, gate_tgl_q, tgl_en_q};
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers; rst_n is the power-on/brown-out reset, no other reset touches ctrl_q
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
         tgl_en_q <= 1'b0;
         count_q <= COUNT_RESET;
         ps_q <= 3'b000;
         instr_q <= 2'b00;
         gate_tgl_q <= 1'b0;
         wr_pend_q <= 1'b0;
         addr_q <= 12'h000;
         rdata_q <= 32'h0000_0000;
         osc_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         if (wr_gate)
            tgl_en_q <= hwdata[TGL_BIT];
         count_q <= count_d;
         ps_q <= ps_d;
         instr_q <= 2'(instr_q + 2'b01);
         if (!ctrl_q.run || !tgl_en_q)
            gate_tgl_q <= 1'b0;
         else if (gate_rise)
            gate_tgl_q <= ~gate_tgl_q;
         wr_pend_q <= a_valid & hwrite;
         if (a_valid)
            addr_q <= a_word;
         if (a_valid & ~hwrite)
            rdata_q <= rd_mux;
         osc_q <= ctrl_d.osc_en;
         tick_q <= inc;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = unused_lvls & 1'b0;
   assign hrdata = rdata_q;
   assign osc_power_en = osc_q;
   assign gate_toggle = gate_tgl_q;
   assign count_tick = tick_q;
endmodule

// *** timer_clock_source_control_chk.sv ***
// checker: control register and count rate properties
`timescale 1ns/1ns
module timer_clock_source_control_chk
   import tmr_pkg::*;
(
   // clock, reset and bus
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // block outputs
   input wire logic osc_power_en,
   input wire logic gate_toggle,
   input wire logic count_tick
);
   logic wr_q;
   logic rd_q;
   logic [7:0] sh_q;
   logic [3:0] age_q;
   wire take = hsel & hready & htrans[1] & ((haddr & ADDR_MASK) == CTRL_ADDR);
   wire [7:0] mode = sh_q & 8'hf1;
   wire settled = age_q > 4'h8;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      wr_q <= rst_n & take & hwrite;
      rd_q <= rst_n & take & !hwrite;
      sh_q <= !rst_n ? 8'h00 : wr_q ? hwdata[7:0] & CTRL_WMASK : sh_q;
      // saturates so a long run never falls back into the settle window
      age_q <= (!rst_n | wr_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence gap3;
      !count_tick [*3] ##1 count_tick;
   endsequence
   sequence gap7;
      !count_tick [*7] ##1 count_tick;
   endsequence
   a_bit1_zero: assert property (rd_q |-> hrdata[1] == 1'b0 && hrdata[31:8] == 24'h00_0000)
      else $error("unimplemented control bits read nonzero");
   a_ctrl_read: assert property (rd_q |-> hrdata[7:0] == $past(sh_q))
      else $error("control register read differs");
   a_osc_follow: assert property (age_q >= 4'h2 |-> osc_power_en == sh_q[OSC_BIT])
      else $error("oscillator power differs from enable bit");
   a_stop_quiet: assert property (age_q > 4'h2 && !sh_q[RUN_BIT] |-> !count_tick && !gate_toggle)
      else $error("counting or toggle flop active while stopped");
   a_sys_rate: assert property (settled && mode == 8'h41 |-> count_tick)
      else $error("system clock source missed a count");
   // a control write ends the rate window, so it aborts the checks in flight
   a_instr_rate: assert property (disable iff (!rst_n || wr_q) settled && mode == 8'h01 && count_tick |=> gap3)
      else $error("instruction clock source not one in four");
   a_ps2_rate: assert property (disable iff (!rst_n || wr_q)
      settled && mode == 8'h51 && count_tick |=> !count_tick ##1 count_tick)
      else $error("prescale by two wrong");
   a_ps8_rate: assert property (disable iff (!rst_n || wr_q) settled && mode == 8'h71 && count_tick |=> gap7)
      else $error("prescale by eight wrong");
endmodule
bind timer_clock_source_control timer_clock_source_control_chk chk_i (
   .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .osc_power_en(osc_power_en), .gate_toggle(gate_toggle), .count_tick(count_tick)
);

// *** timer_clock_source_control_test.sv ***
// testbench: every source and prescale code, count checks over the bus
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module timer_clock_source_control_test
   import tmr_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready, hresp, osc_power_en, gate_toggle, count_tick;
   logic [31:0] hrdata, rd;
   ext_in_s ext_in;
   int error_cnt = 0, n_tests = 0, cyc = 0, seed = 32'hee78b869;
   always #5 clk_sys = !clk_sys;
   ext_source_model PART (.ext_in(ext_in));
   timer_clock_source_control DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .ext_in(ext_in),
      .osc_power_en(osc_power_en), .gate_toggle(gate_toggle), .count_tick(count_tick));
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         close_out();
      end
   end
   // gate flop changes, counted for the toggle check
   int flips = 0;
   logic tgl_prev = 1'b0;
   always @(posedge clk_sys) begin
      tgl_prev <= gate_toggle;
      if (gate_toggle !== tgl_prev) begin
         flips <= flips + 1;
      end
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // source period in ns, widened by the prescale
   function automatic logic [15:0] exp_cnt(input logic [7:0] c, input logic [15:0] s, input int n);
      int per;
      per = c[7:6] == SRC_INSTR ? 40 : c[7:6] == SRC_SYS ? 10 : c[7:6] == SRC_CAP ? 52 : c[OSC_BIT] ? 92 : 72;
      return s + 16'(n * 10 / (per << c[5:4]));
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] c;
      logic [15:0] s;
      logic [15:0] d;
      int f;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      xfer(1'b0, CTRL_ADDR, 32'h0000_0000);
      `CHK("ctrl reset", 32'h0000_0000, rd)
      xfer(1'b1, CTRL_ADDR, 32'hffff_fffe);
      xfer(1'b0, CTRL_ADDR, 32'h0000_0000);
      `CHK("ctrl bits", 32'h0000_00fc, rd)
      `CHK("osc power", 1'b1, osc_power_en)
      xfer(1'b0, 12'h0f0, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rd)
      `CHK("okay response", 1'b0, hresp)
      xfer(1'b1, GATE_ADDR, 32'h0000_0001);
      // a fixed margin of two covers sync latency and edge phase
      for (int i = 0; i < 17; i++) begin
         c = {i[3:0], 4'h1} | (8'($random(seed)) & (i > 7 ? 8'h0c : 8'h00));
         s = i > 15 ? 16'hffd0 : 16'($random(seed));
         c = i > 15 ? 8'h41 : c;
         xfer(1'b1, COUNT_ADDR, {16'h0000, s});
         xfer(1'b1, CTRL_ADDR, {24'h00_0000, c});
         f = flips;
         repeat (64) @(posedge clk_sys);
         xfer(1'b1, CTRL_ADDR, 32'h0000_0000);
         xfer(1'b0, COUNT_ADDR, 32'h0000_0000);
         d = rd[15:0] - exp_cnt(c, s, 66) + 16'h0002;
         `CHK("count", 1'b1, d <= 16'h0004)
         `CHK("toggle flop", 1'b0, gate_toggle)
         // 66 running cycles hold five or six rises of the 112 ns gate source
         `CHK("toggle flips", 1'b1, (flips - f) >= 5 && (flips - f) <= 6)
      end
      // second reset in mid-run clears the control register again
      xfer(1'b1, CTRL_ADDR, 32'h0000_00c9);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      xfer(1'b0, CTRL_ADDR, 32'h0000_0000);
      `CHK("ctrl after reset", 32'h0000_0000, rd)
      `CHK("osc after reset", 1'b0, osc_power_en)
      close_out();
   end
endmodule

// *** tmr_pkg.sv ***
// package: register map, field layout and bus types for the timer clock source block
package tmr_pkg;
   // register byte addresses
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] COUNT_ADDR = 12'h004;
   localparam logic [11:0] GATE_ADDR = 12'h008;
   localparam logic [11:0] ADDR_MASK = 12'hFFC;
   // counter_control field positions
   localparam int RUN_BIT = 0;
   localparam int SYNC_BIT = 2;
   localparam int OSC_BIT = 3;
   localparam int PS_LO = 4;
   localparam int CS_LO = 6;
   localparam logic [7:0] CTRL_WMASK = 8'hFD;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   // gate register bit: toggle mode enable
   localparam int TGL_BIT = 0;
   // count source codes
   localparam logic [1:0] SRC_INSTR = 2'b00;
   localparam logic [1:0] SRC_SYS = 2'b01;
   localparam logic [1:0] SRC_PIN = 2'b10;
   localparam logic [1:0] SRC_CAP = 2'b11;
   // instruction clock is the system clock divided by four
   localparam logic [1:0] INSTR_DIV_LAST = 2'b11;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] HTRANS_SEQ = 2'b11;

   typedef struct packed {
      logic [1:0] src;
      logic [1:0] ps;
      logic osc_en;
      logic sync_bypass;
      logic rsvd;
      logic run;
   } ctrl_s;

   typedef struct packed {
      logic ext_pin;
      logic xtal;
      logic cap_osc;
      logic gate;
   } ext_in_s;
endpackage
